// ===== ccmc_host_model.sv
// Purpose: audio host model on the frame and bit clock pins
// Assumes: pull-down resistors on both clock lines
// Notes:   the codec gives no lock flag, so the host counts the wait

`timescale 1ns/1ps
`default_nettype none

// ************************************************************
// host model
// ************************************************************
module ccmc_host_model #(
  parameter int LOCK_CYCLES = 64  // shortened stand-in for lock time
) (
  // clock and reset
  input  wire logic clk,
  input  wire logic rst,
  // codec pins
  input  wire logic frame_o,
  input  wire logic frame_oe_n,
  input  wire logic bit_o,
  input  wire logic bit_oe_n,
  input  wire logic relock,
  // resolved lines and host state
  output logic      frame_wire,
  output logic      bit_wire,
  output logic      mclk_in,
  output logic      lock_busy
);
  int unsigned wait_ff;  // cycles left before clocks are trusted

  // a released line falls to the pull-down level
  assign frame_wire = frame_oe_n ? 1'b0 : frame_o;
  assign bit_wire   = bit_oe_n ? 1'b0 : bit_o;
  // master clock input kept grounded
  assign mclk_in    = 1'b0;
  // busy while the lock wait runs
  assign lock_busy  = (wait_ff != 0);

  // restart the wait on every pll start or rate change with pll on
  always_ff @(posedge clk) begin
    if (rst) begin
      wait_ff <= 0;
    end else if (relock) begin
      wait_ff <= LOCK_CYCLES;
    end else if (wait_ff != 0) begin
      wait_ff <= wait_ff - 1;
    end
  end
endmodule

`default_nettype wire

// ===== ccmc_pkg.sv
// Purpose: shared constants and types for the codec clock-mode control
// Assumes: 50 MHz system clock, configuration bits presented as one word
// Notes:   sampling periods are whole system-clock cycles per frame

// ************************************************************
// package
// ************************************************************
package ccmc_pkg;

  // system clock rate
  localparam int CLK_HZ = 50000000;

  // configuration word carried from the host side
  typedef struct packed {
    logic       pll_power;          // pll powered, pll makes clocks
    logic       master_select;      // 1 master, 0 slave
    logic       mclk_out_enable;    // master clock output enable
    logic [3:0] pll_ref_select;     // pll reference source and rate
    logic [3:0] rate_select;        // sampling rate or range code
    logic [1:0] mclk_out_divider;   // master clock output ratio
    logic       bitclk_ratio_select; // 0 gives 32fs, 1 gives 64fs
  } ccmc_cfg_t;

  // configuration defaults after reset
  localparam ccmc_cfg_t CFG_RESET = '{
    pll_power:           1'b0,
    master_select:       1'b0,
    mclk_out_enable:     1'b0,
    pll_ref_select:      4'h0,
    rate_select:         4'h0,
    mclk_out_divider:    2'h0,
    bitclk_ratio_select: 1'b0
  };

  // clock modes
  typedef enum logic [2:0] {
    MODE_EXT_SLAVE,
    MODE_PLL_MASTER,
    MODE_PLL_SLAVE_MCLK,
    MODE_PLL_SLAVE_FRAME,
    MODE_UNSUPPORTED
  } ccmc_mode_t;

  // position of the reference source bit in the reference field
  localparam int REF_SOURCE_BIT = 2;
  // position of the ignored rate bit for frame or bit references
  localparam int RATE_IGNORED_BIT = 2;

  // reference field codes
  localparam logic [3:0] REF_FRAME_1FS  = 4'h0;
  localparam logic [3:0] REF_BIT_32FS   = 4'h2;
  localparam logic [3:0] REF_BIT_64FS   = 4'h3;
  localparam logic [3:0] REF_MCLK_11M29 = 4'h4;
  localparam logic [3:0] REF_MCLK_12M29 = 4'h5;
  localparam logic [3:0] REF_MCLK_12M   = 4'h6;
  localparam logic [3:0] REF_MCLK_24M   = 4'h7;
  localparam logic [3:0] REF_MCLK_13M5  = 4'hc;
  localparam logic [3:0] REF_MCLK_27M   = 4'hd;

  // sampling range codes for frame or bit references
  localparam logic [2:0] RANGE_8K  = 3'h0;
  localparam logic [2:0] RANGE_12K = 3'h1;
  localparam logic [2:0] RANGE_16K = 3'h2;
  localparam logic [2:0] RANGE_24K = 3'h3;
  localparam logic [2:0] RANGE_32K = 3'h6;

  // sampling rates in hertz
  localparam int FS_8000  = 8000;
  localparam int FS_12000 = 12000;
  localparam int FS_16000 = 16000;
  localparam int FS_24000 = 24000;
  localparam int FS_7350  = 7350;
  localparam int FS_11025 = 11025;
  localparam int FS_14700 = 14700;
  localparam int FS_22050 = 22050;
  localparam int FS_32000 = 32000;
  localparam int FS_48000 = 48000;
  localparam int FS_29400 = 29400;
  localparam int FS_44100 = 44100;

  // frame period in system clock cycles, rate code to count
  localparam int PW = 16;
  localparam logic [PW-1:0] PER_8000  = PW'(CLK_HZ / FS_8000);
  localparam logic [PW-1:0] PER_12000 = PW'(CLK_HZ / FS_12000);
  localparam logic [PW-1:0] PER_16000 = PW'(CLK_HZ / FS_16000);
  localparam logic [PW-1:0] PER_24000 = PW'(CLK_HZ / FS_24000);
  localparam logic [PW-1:0] PER_7350  = PW'(CLK_HZ / FS_7350);
  localparam logic [PW-1:0] PER_11025 = PW'(CLK_HZ / FS_11025);
  localparam logic [PW-1:0] PER_14700 = PW'(CLK_HZ / FS_14700);
  localparam logic [PW-1:0] PER_22050 = PW'(CLK_HZ / FS_22050);
  localparam logic [PW-1:0] PER_32000 = PW'(CLK_HZ / FS_32000);
  localparam logic [PW-1:0] PER_48000 = PW'(CLK_HZ / FS_48000);
  localparam logic [PW-1:0] PER_29400 = PW'(CLK_HZ / FS_29400);
  localparam logic [PW-1:0] PER_44100 = PW'(CLK_HZ / FS_44100);

  // shift that turns a frame period into a half bit-clock period
  localparam logic [3:0] SHIFT_BIT_32FS = 4'h6;
  localparam logic [3:0] SHIFT_BIT_64FS = 4'h7;
  // shift for a half master-clock period at 256fs, less divider code
  localparam logic [3:0] SHIFT_MCLK_256FS = 4'h9;
  // bit clocks per half frame
  localparam logic [5:0] HALF_FRAME_32FS = 6'h10;
  localparam logic [5:0] HALF_FRAME_64FS = 6'h20;

endpackage

// ===== ccmc_tick_div.sv
// Purpose: programmable divider giving a one-cycle tick
// Assumes: half period counted in system clock cycles
// Notes:   a half period of zero behaves as one

`timescale 1ns/1ps
`default_nettype none

// ************************************************************
// tick divider
// ************************************************************
module ccmc_tick_div (
  // clock and reset
  input  wire logic                    clk,
  input  wire logic                    rst,
  // control
  input  wire logic                    run,
  input  wire logic [ccmc_pkg::PW-1:0] half,
  // tick out
  output logic                         tick
);

  logic [ccmc_pkg::PW-1:0] cnt_ff;  // cycles since last tick

  // count up to the half period, tick and restart
  always_ff @(posedge clk) begin
    if (rst || !run) begin
      cnt_ff <= '0;
      tick   <= 1'b0;
    end else if (cnt_ff + 1'b1 >= half) begin
      cnt_ff <= '0;
      tick   <= 1'b1;
    end else begin
      cnt_ff <= cnt_ff + 1'b1;
      tick   <= 1'b0;
    end
  end

endmodule

`default_nettype wire

// ===== ccmc_top.sv
// Purpose: clock-mode control for a stereo codec
// Assumes: host presents configuration with a write strobe
// Notes:   master clocks are made from the system clock by dividers

`timescale 1ns/1ps
`default_nettype none

module ccmc_top (
  // clock and reset
  input  wire logic                CLK,
  input  wire logic                SYS_RST,
  // power-down pin, low resets
  input  wire logic                POWERDOWN_N,
  // configuration write
  input  wire logic                CFG_WE,
  input  wire ccmc_pkg::ccmc_cfg_t CFG_WDATA,
  // master clock output pin
  output logic                     MCLK_OUT,
  // frame clock pin, enable low drives
  output logic                     FRAME_CLOCK_O,
  output logic                     FRAME_CLOCK_OE_N,
  // bit clock pin, enable low drives
  output logic                     BIT_CLOCK_O,
  output logic                     BIT_CLOCK_OE_N,
  // status
  output ccmc_pkg::ccmc_mode_t     CLOCK_MODE,
  output logic                     MCLK_INVALID,
  output logic                     PLL_ENABLE,
  output logic                     REF_VALID,
  output logic                     RATE_VALID,
  output logic [2:0]               FS_RANGE,
  output logic                     RANGE_VALID,
  output logic                     RELOCK
);

  // ************************************************************
  // declarations
  // ************************************************************
  logic                          rst;           // system or power-down
  ccmc_pkg::ccmc_cfg_t           cfg_ff;        // held configuration
  ccmc_pkg::ccmc_mode_t          nxt_mode;      // decoded mode
  logic                          nxt_ref_ok;    // reference code valid
  logic                          nxt_rate_ok;   // rate code valid
  logic [ccmc_pkg::PW-1:0]       nxt_period;    // frame period cycles
  logic [2:0]                    nxt_range;     // range code
  logic                          nxt_range_ok;  // range code valid
  logic [ccmc_pkg::PW-1:0]       period_ff;     // registered period
  logic [ccmc_pkg::PW-1:0]       bit_half;      // half bit period
  logic [ccmc_pkg::PW-1:0]       mclk_half;     // half mclk period
  logic                          master_run;    // master clocks run
  logic                          mclk_run;      // mclk divider runs
  logic                          bit_tick;      // bit clock edge tick
  logic                          mclk_tick;     // mclk edge tick
  logic [5:0]                    bitcnt_ff;     // bits in half frame
  logic [5:0]                    half_frame;    // bits per half frame

  assign rst = SYS_RST || !POWERDOWN_N;

  // ************************************************************
  // configuration
  // ************************************************************
  // load on write, defaults on either reset, slave by default
  always_ff @(posedge CLK) begin
    if (rst) begin
      cfg_ff <= ccmc_pkg::CFG_RESET;
    end else if (CFG_WE) begin
      cfg_ff <= CFG_WDATA;
    end
  end

  // ************************************************************
  // mode and code decode
  // ************************************************************
  // mode from pll power and master bits
  always_comb begin
    case ({cfg_ff.pll_power, cfg_ff.master_select})
      2'b11:   nxt_mode = ccmc_pkg::MODE_PLL_MASTER;
      2'b10: begin
        // slave: reference source picks which pll slave mode
        if (cfg_ff.pll_ref_select[ccmc_pkg::REF_SOURCE_BIT]) begin
          nxt_mode = ccmc_pkg::MODE_PLL_SLAVE_MCLK;
        end else begin
          nxt_mode = ccmc_pkg::MODE_PLL_SLAVE_FRAME;
        end
      end
      2'b01:   nxt_mode = ccmc_pkg::MODE_UNSUPPORTED;
      default: nxt_mode = ccmc_pkg::MODE_EXT_SLAVE;
    endcase
  end

  // reference field decode
  always_comb begin
    case (cfg_ff.pll_ref_select)
      ccmc_pkg::REF_FRAME_1FS,
      ccmc_pkg::REF_BIT_32FS,
      ccmc_pkg::REF_BIT_64FS,
      ccmc_pkg::REF_MCLK_11M29,
      ccmc_pkg::REF_MCLK_12M29,
      ccmc_pkg::REF_MCLK_12M,
      ccmc_pkg::REF_MCLK_24M,
      ccmc_pkg::REF_MCLK_13M5,
      ccmc_pkg::REF_MCLK_27M: nxt_ref_ok = 1'b1;
      default:                nxt_ref_ok = 1'b0;
    endcase
  end

  // rate field to frame period for mclk reference
  always_comb begin
    nxt_rate_ok = 1'b1;
    case (cfg_ff.rate_select)
      4'h0:    nxt_period = ccmc_pkg::PER_8000;
      4'h1:    nxt_period = ccmc_pkg::PER_12000;
      4'h2:    nxt_period = ccmc_pkg::PER_16000;
      4'h3:    nxt_period = ccmc_pkg::PER_24000;
      4'h4:    nxt_period = ccmc_pkg::PER_7350;
      4'h5:    nxt_period = ccmc_pkg::PER_11025;
      4'h6:    nxt_period = ccmc_pkg::PER_14700;
      4'h7:    nxt_period = ccmc_pkg::PER_22050;
      4'ha:    nxt_period = ccmc_pkg::PER_32000;
      4'hb:    nxt_period = ccmc_pkg::PER_48000;
      4'he:    nxt_period = ccmc_pkg::PER_29400;
      4'hf:    nxt_period = ccmc_pkg::PER_44100;
      default: begin
        // unsupported code: no period, bit and frame clocks stay stopped, master clock ticks every cycle
        nxt_period  = '0;
        nxt_rate_ok = 1'b0;
      end
    endcase
  end

  // range from rate bits 3, 1 and 0; bit 2 never looked at
  always_comb begin
    nxt_range = {cfg_ff.rate_select[3], cfg_ff.rate_select[1:0]};
    case (nxt_range)
      ccmc_pkg::RANGE_8K,
      ccmc_pkg::RANGE_12K,
      ccmc_pkg::RANGE_16K,
      ccmc_pkg::RANGE_24K,
      ccmc_pkg::RANGE_32K: nxt_range_ok = 1'b1;
      default:             nxt_range_ok = 1'b0;
    endcase
  end

  // ************************************************************
  // status registers
  // ************************************************************
  // register decoded state; rate only counts with mclk reference
  always_ff @(posedge CLK) begin
    if (rst) begin
      CLOCK_MODE   <= ccmc_pkg::MODE_EXT_SLAVE;
      MCLK_INVALID <= 1'b0;
      PLL_ENABLE   <= 1'b0;
      REF_VALID    <= 1'b0;
      RATE_VALID   <= 1'b0;
      FS_RANGE     <= ccmc_pkg::RANGE_8K;
      RANGE_VALID  <= 1'b0;
      period_ff    <= '0;
    end else begin
      CLOCK_MODE   <= nxt_mode;
      MCLK_INVALID <= (nxt_mode == ccmc_pkg::MODE_UNSUPPORTED) &&
                      cfg_ff.mclk_out_enable;
      PLL_ENABLE   <= cfg_ff.pll_power;
      REF_VALID    <= nxt_ref_ok;
      RATE_VALID   <= nxt_rate_ok &&
                      cfg_ff.pll_ref_select[ccmc_pkg::REF_SOURCE_BIT];
      FS_RANGE     <= nxt_range;
      RANGE_VALID  <= nxt_range_ok &&
                      !cfg_ff.pll_ref_select[ccmc_pkg::REF_SOURCE_BIT];
      period_ff    <= nxt_period;
    end
  end

  // pulse when pll powers up or rate changes with pll on: host lock wait starts
  always_ff @(posedge CLK) begin
    if (rst) begin
      RELOCK <= 1'b0;
    end else begin
      RELOCK <= CFG_WE && CFG_WDATA.pll_power &&
                (!cfg_ff.pll_power ||
                 CFG_WDATA.rate_select != cfg_ff.rate_select);
    end
  end

  // ************************************************************
  // clock generation
  // ************************************************************
  // pll makes clocks only when powered with mclk rate table
  assign master_run = (CLOCK_MODE == ccmc_pkg::MODE_PLL_MASTER) &&
                      RATE_VALID;
  // mclk divider runs with output enabled, for pll modes and the unsupported mode
  assign mclk_run   = cfg_ff.mclk_out_enable &&
                      (cfg_ff.pll_power || cfg_ff.master_select);
  assign bit_half   = period_ff >> (cfg_ff.bitclk_ratio_select ?
                      ccmc_pkg::SHIFT_BIT_64FS :
                      ccmc_pkg::SHIFT_BIT_32FS);
  assign mclk_half  = period_ff >> (ccmc_pkg::SHIFT_MCLK_256FS -
                      {2'h0, cfg_ff.mclk_out_divider});
  assign half_frame = cfg_ff.bitclk_ratio_select ?
                      ccmc_pkg::HALF_FRAME_64FS :
                      ccmc_pkg::HALF_FRAME_32FS;

  // bit clock edge ticks
  ccmc_tick_div u_bit_div (
    .clk  (CLK),
    .rst  (rst),
    .run  (master_run),
    .half (bit_half),
    .tick (bit_tick)
  );

  // master clock output edge ticks
  ccmc_tick_div u_mclk_div (
    .clk  (CLK),
    .rst  (rst),
    .run  (mclk_run),
    .half (mclk_half),
    .tick (mclk_tick)
  );

  // master clock pin: low when disabled, else toggles per tick
  always_ff @(posedge CLK) begin
    if (rst || !mclk_run) begin
      MCLK_OUT <= 1'b0;
    end else if (mclk_tick) begin
      MCLK_OUT <= !MCLK_OUT;
    end
  end

  // bit and frame clock, frame flips each half frame of bits
  always_ff @(posedge CLK) begin
    if (rst || !master_run) begin
      BIT_CLOCK_O   <= 1'b0;
      FRAME_CLOCK_O <= 1'b0;
      bitcnt_ff     <= '0;
    end else if (bit_tick) begin
      BIT_CLOCK_O <= !BIT_CLOCK_O;
      // frame changes on the falling bit clock edge
      if (BIT_CLOCK_O) begin
        if (bitcnt_ff + 6'h1 >= half_frame) begin
          bitcnt_ff     <= '0;
          FRAME_CLOCK_O <= !FRAME_CLOCK_O;
        end else begin
          bitcnt_ff <= bitcnt_ff + 6'h1;
        end
      end
    end
  end

  // pins are driven only in master mode, floating otherwise
  always_ff @(posedge CLK) begin
    if (rst) begin
      FRAME_CLOCK_OE_N <= 1'b1;
      BIT_CLOCK_OE_N   <= 1'b1;
    end else begin
      FRAME_CLOCK_OE_N <= !(cfg_ff.master_select && cfg_ff.pll_power);
      BIT_CLOCK_OE_N   <= !(cfg_ff.master_select && cfg_ff.pll_power);
    end
  end

  // ************************************************************
  // assertions
  // ************************************************************
  a_reset_slave: assert property (@(posedge CLK)
    rst |=> !cfg_ff.master_select && CLOCK_MODE != ccmc_pkg::MODE_PLL_MASTER)
    else $error("not slave after reset");

  a_mode_master: assert property (@(posedge CLK) disable iff (rst)
    cfg_ff.pll_power && cfg_ff.master_select |=>
      CLOCK_MODE == ccmc_pkg::MODE_PLL_MASTER)
    else $error("pll master mode not selected");

  a_mode_ext: assert property (@(posedge CLK) disable iff (rst)
    !cfg_ff.pll_power && !cfg_ff.master_select |=>
      CLOCK_MODE == ccmc_pkg::MODE_EXT_SLAVE)
    else $error("external slave mode not selected");

  a_mclk_invalid: assert property (@(posedge CLK) disable iff (rst)
    !cfg_ff.pll_power && cfg_ff.master_select &&
      cfg_ff.mclk_out_enable |=> MCLK_INVALID)
    else $error("unsupported mode not flagged");

  a_mclk_low: assert property (@(posedge CLK) disable iff (rst)
    !cfg_ff.mclk_out_enable [*2] |-> !MCLK_OUT)
    else $error("master clock out not low");

  a_pins_float: assert property (@(posedge CLK) disable iff (rst)
    !cfg_ff.master_select |=> FRAME_CLOCK_OE_N && BIT_CLOCK_OE_N)
    else $error("clock pins driven in slave");

  a_ref_decode: assert property (@(posedge CLK) disable iff (rst)
    cfg_ff.pll_ref_select == 4'h1 || cfg_ff.pll_ref_select == 4'h8 |=>
      !REF_VALID)
    else $error("bad reference code accepted");

  a_rate_decode: assert property (@(posedge CLK) disable iff (rst)
    cfg_ff.pll_ref_select[2] && cfg_ff.rate_select == 4'hb |=>
      RATE_VALID && period_ff == ccmc_pkg::PER_48000)
    else $error("rate code 48k wrong");

  a_range_nobit2: assert property (@(posedge CLK) disable iff (rst)
    $stable({cfg_ff.rate_select[3], cfg_ff.rate_select[1:0]}) &&
      !$stable(cfg_ff.rate_select[2]) |=> $stable(FS_RANGE))
    else $error("range follows rate bit2");

endmodule

`default_nettype wire

// ===== ccmc_top_bench.sv
// Purpose: self-checking bench for the codec clock-mode control
// Assumes: inputs driven 1 ns after the rising edge
// Notes:   frame and bit toggle counts are taken on the host side of the pins, master clock on the codec pin

`timescale 1ns/1ps
`default_nettype none

// ************************************************************
// bench
// ************************************************************
module ccmc_top_bench;
  logic                 clk;        // 50 MHz clock
  logic                 sys_rst;    // synchronous reset
  logic                 pdn_n;      // power-down pin
  logic                 cfg_we;     // config write strobe
  ccmc_pkg::ccmc_cfg_t  cfg_wdata;  // config word
  logic                 mclk_out;   // master clock out
  logic                 fr_o;       // frame clock value
  logic                 fr_oe_n;    // frame clock enable
  logic                 bc_o;       // bit clock value
  logic                 bc_oe_n;    // bit clock enable
  ccmc_pkg::ccmc_mode_t mode;       // decoded mode
  logic                 mclk_inv;   // invalid mclk flag
  logic                 pll_en;     // pll enabled
  logic                 ref_ok;     // reference code valid
  logic                 rate_ok;    // rate code valid
  logic [2:0]           fs_range;   // range code
  logic                 range_ok;   // range code valid
  logic                 relock;     // lock restart pulse
  logic                 fr_w;       // resolved frame line
  logic                 bc_w;       // resolved bit line
  logic                 lock_busy;  // host lock wait
  logic                 mq, fq, bq; // last seen line levels
  int                   n_errors, checked, cycles, n_relock;
  int                   n_mclk, n_frame, n_bit;

  // design and host
  ccmc_top DUT (.CLK(clk), .SYS_RST(sys_rst), .POWERDOWN_N(pdn_n),
    .CFG_WE(cfg_we), .CFG_WDATA(cfg_wdata), .MCLK_OUT(mclk_out),
    .FRAME_CLOCK_O(fr_o), .FRAME_CLOCK_OE_N(fr_oe_n),
    .BIT_CLOCK_O(bc_o), .BIT_CLOCK_OE_N(bc_oe_n), .CLOCK_MODE(mode),
    .MCLK_INVALID(mclk_inv), .PLL_ENABLE(pll_en), .REF_VALID(ref_ok),
    .RATE_VALID(rate_ok), .FS_RANGE(fs_range), .RANGE_VALID(range_ok),
    .RELOCK(relock));
  ccmc_host_model host (.clk(clk), .rst(sys_rst), .frame_o(fr_o),
    .frame_oe_n(fr_oe_n), .bit_o(bc_o), .bit_oe_n(bc_oe_n),
    .relock(relock), .frame_wire(fr_w), .bit_wire(bc_w),
    .mclk_in(), .lock_busy(lock_busy));

  // clock
  always #10 clk = ~clk;

  // toggle counters and hang guard
  always @(posedge clk) begin
    mq = mclk_out;
    fq = fr_w;
    bq = bc_w;
    #2;
    if (mclk_out !== mq) n_mclk++;
    if (fr_w !== fq) n_frame++;
    if (bc_w !== bq) n_bit++;
    cycles++;
    if (cycles == 20000) begin
      n_errors++;
      tally_and_finish();
    end
  end

  // ************************************************************
  // helpers
  // ************************************************************
  task automatic tick();
    @(posedge clk);
    #1;
  endtask

  // one-bit compare
  task automatic chk_bit(input logic got, input logic exp);
    checked++;
    if (got !== exp) begin
      n_errors++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // vector compare
  task automatic chk_vec(input logic [7:0] got, input logic [7:0] exp);
    checked++;
    if (got !== exp) begin
      n_errors++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // build a config word
  function automatic ccmc_pkg::ccmc_cfg_t mk(input logic p, m, e,
      input logic [3:0] r, s, input logic b);
    mk = ccmc_pkg::CFG_RESET;
    mk.pll_power = p;
    mk.master_select = m;
    mk.mclk_out_enable = e;
    mk.pll_ref_select = r;
    mk.rate_select = s;
    mk.bitclk_ratio_select = b;
  endfunction

  // one write, relock pulses counted until status settles
  task automatic wr(input ccmc_pkg::ccmc_cfg_t c);
    tick();
    cfg_we = 1'b1;
    cfg_wdata = c;
    tick();
    cfg_we = 1'b0;
    n_relock = 0;
    repeat (4) begin
      if (relock === 1'b1) n_relock++;
      tick();
    end
  endtask

  // clear counters and watch the lines
  task automatic watch(input int n);
    n_mclk = 0;
    n_frame = 0;
    n_bit = 0;
    repeat (n) tick();
  endtask

  // ************************************************************
  // scenarios
  // ************************************************************
  // defaults after reset: slave, pins released
  task automatic t_reset();
    chk_vec(8'(mode), 8'(ccmc_pkg::MODE_EXT_SLAVE));
    chk_bit(fr_oe_n, 1'b1);
    chk_bit(fr_w, 1'b0);
    chk_bit(pll_en, 1'b0);
  endtask

  // the four mode combinations
  task automatic t_modes();
    ccmc_pkg::ccmc_mode_t em [4];
    em = '{ccmc_pkg::MODE_EXT_SLAVE, ccmc_pkg::MODE_UNSUPPORTED,
           ccmc_pkg::MODE_PLL_SLAVE_MCLK, ccmc_pkg::MODE_PLL_MASTER};
    for (int i = 0; i < 4; i++) begin
      wr(mk(i[1], i[0], 1'b1, 4'h4, 4'hb, 1'b0));
      chk_vec(8'(mode), 8'(em[i]));
      chk_bit(mclk_inv, !i[1] && i[0]);
      chk_bit(bc_oe_n, !(i[1] && i[0]));
      chk_bit(pll_en, i[1]);
    end
    wr(mk(1'b1, 1'b0, 1'b0, 4'h0, 4'h0, 1'b0));
    chk_vec(8'(mode), 8'(ccmc_pkg::MODE_PLL_SLAVE_FRAME));
  endtask

  // every reference and rate code
  task automatic t_codes();
    for (int i = 0; i < 16; i++) begin
      wr(mk(1'b1, 1'b0, 1'b0, 4'(i), 4'h0, 1'b0));
      chk_bit(ref_ok, i inside {0, 2, 3, 4, 5, 6, 7, 12, 13});
      wr(mk(1'b1, 1'b0, 1'b0, 4'h4, 4'(i), 1'b0));
      chk_bit(rate_ok, !(i inside {8, 9, 12, 13}));
      chk_bit(range_ok, 1'b0);
      wr(mk(1'b1, 1'b0, 1'b0, 4'h0, 4'(i), 1'b0));
      chk_vec(8'(fs_range), {5'h0, i[3], i[1], i[0]});
      chk_bit(range_ok, (i & 11) inside {0, 1, 2, 3, 10});
      chk_bit(rate_ok, 1'b0);
    end
  endtask

  // pll start and rate change restart the lock wait
  task automatic t_relock();
    wr(mk(1'b0, 1'b0, 1'b0, 4'h4, 4'hb, 1'b0));
    chk_vec(8'(n_relock), 8'h0);
    wr(mk(1'b1, 1'b0, 1'b0, 4'h4, 4'hb, 1'b0));
    chk_vec(8'(n_relock), 8'h1);
    wr(mk(1'b1, 1'b0, 1'b0, 4'h4, 4'hb, 1'b0));
    chk_vec(8'(n_relock), 8'h0);
    wr(mk(1'b1, 1'b0, 1'b0, 4'h4, 4'h3, 1'b0));
    chk_vec(8'(n_relock), 8'h1);
  endtask

  // master clocks at both bit ratios, then output disabled
  task automatic t_master();
    int k;
    int h;
    ccmc_pkg::ccmc_cfg_t c;
    for (int b = 0; b < 2; b++) begin
      wr(mk(1'b1, 1'b1, 1'b1, 4'h4, 4'hb, b[0]));
      k = 0;
      while (lock_busy === 1'b1 && k < 200) begin
        tick();
        k++;
      end
      chk_bit(lock_busy, 1'b0);
      watch(1500);
      chk_bit(n_mclk > 100, 1'b1);
      chk_bit(n_frame > 0, 1'b1);
      chk_bit(n_bit >= 32 * (b + 1) * (n_frame - 1), 1'b1);
      chk_bit(n_bit <= 32 * (b + 1) * (n_frame + 1), 1'b1);
    end
    // divider code 3 gives a 32fs master clock: half period fs/64
    c = mk(1'b1, 1'b1, 1'b1, 4'h4, 4'hb, 1'b0);
    c.mclk_out_divider = 2'h3;
    wr(c);
    h = int'(ccmc_pkg::PER_48000) / 64;
    watch(1500);
    chk_bit(n_mclk >= 1500 / h - 1, 1'b1);
    chk_bit(n_mclk <= 1500 / h + 1, 1'b1);
    wr(mk(1'b1, 1'b1, 1'b0, 4'h4, 4'hb, 1'b0));
    watch(300);
    chk_vec(8'(n_mclk), 8'h0);
    chk_bit(mclk_out, 1'b0);
  endtask

  // external slave ignores the reference, pins stay released
  task automatic t_ext();
    wr(mk(1'b0, 1'b0, 1'b1, 4'h4, 4'hb, 1'b0));
    watch(300);
    chk_vec(8'(mode), 8'(ccmc_pkg::MODE_EXT_SLAVE));
    chk_vec(8'(n_mclk), 8'h0);
    chk_vec(8'(n_frame), 8'h0);
    chk_vec(8'(n_bit), 8'h0);
    chk_bit(fr_oe_n, 1'b1);
  endtask

  // power-down in mid-run returns to slave
  task automatic t_pdn();
    wr(mk(1'b1, 1'b1, 1'b1, 4'h4, 4'hb, 1'b0));
    pdn_n = 1'b0;
    repeat (2) tick();
    pdn_n = 1'b1;
    tick();
    chk_vec(8'(mode), 8'(ccmc_pkg::MODE_EXT_SLAVE));
    chk_bit(bc_oe_n, 1'b1);
    chk_bit(mclk_out, 1'b0);
    wr(mk(1'b1, 1'b0, 1'b1, 4'h4, 4'hb, 1'b0));
    chk_bit(fr_oe_n, 1'b1);
  endtask

  // verdict
  task automatic tally_and_finish();
    $display("checked=%0d n_errors=%0d", checked, n_errors);
    if (n_errors == 0 && checked > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask

  // main sequence
  initial begin
    clk = 1'b0;
    sys_rst = 1'b1;
    pdn_n = 1'b1;
    cfg_we = 1'b0;
    cfg_wdata = ccmc_pkg::CFG_RESET;
    {n_errors, checked, cycles, n_relock} = '0;
    {n_mclk, n_frame, n_bit} = '0;
    repeat (12) tick();
    sys_rst = 1'b0;
    tick();
    t_reset();
    t_modes();
    t_codes();
    t_relock();
    t_master();
    t_ext();
    t_pdn();
    tally_and_finish();
  end
endmodule

`default_nettype wire
